//--- core/lintmc_pkg.sv
// Package for the LIN transceiver operating-mode controller
package lintmc_pkg;

  // Clock and timebase
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned TICK_PERIOD_NS = 1000;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned TIME_W         = 16;

  // Hold and filter times in ticks
  localparam logic [15:0] MODE_HOLD_US_RST  = 16'h0064;
  localparam logic [15:0] RELEASE_US_RST    = 16'h000a;
  localparam logic [15:0] BUS_FILT_US_RST   = 16'h001e;
  localparam logic [15:0] LOCAL_FILT_US_RST = 16'h001e;
  localparam logic [15:0] FLASH_EN_LOW_US   = 16'h0014;
  localparam logic [15:0] FLASH_EDGE_US     = 16'h0005;
  localparam logic [15:0] FLASH_EDGE2_US    = 16'h0005;

  // Register byte offsets
  localparam logic [31:0] STATUS_OFFSET     = 32'h0000_0000;
  localparam logic [31:0] MODE_HOLD_OFFSET  = 32'h0000_0004;
  localparam logic [31:0] RELEASE_OFFSET    = 32'h0000_0008;
  localparam logic [31:0] BUS_FILT_OFFSET   = 32'h0000_000c;
  localparam logic [31:0] LOCAL_FILT_OFFSET = 32'h0000_0010;

  // Status field positions
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_FLASH_BIT = 4;
  localparam int unsigned STAT_CAUSE_LSB = 5;
  localparam int unsigned STAT_REL_BIT   = 7;
  localparam int unsigned STAT_ARMED_BIT = 8;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Standby entry cause: {receive level, transmit level}
  localparam logic [1:0] CAUSE_PWR   = 2'h2;
  localparam logic [1:0] CAUSE_BUS   = 2'h1;
  localparam logic [1:0] CAUSE_LOCAL = 2'h0;

  // Hold timer indices
  localparam int unsigned TMR_EN    = 0;
  localparam int unsigned TMR_MODE  = 1;
  localparam int unsigned TMR_BUS   = 2;
  localparam int unsigned TMR_LOCAL = 3;
  localparam int unsigned TMR_REL   = 4;
  localparam int unsigned TMR_NUM   = 5;

  typedef enum logic [3:0] {
    ST_NORMAL  = 4'b0001,
    ST_STANDBY = 4'b0010,
    ST_SLEEP   = 4'b0100,
    ST_STOP    = 4'b1000
  } lintmc_state_type;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } lintmc_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } lintmc_axi_resp_type;

endpackage : lintmc_pkg

//--- core/lintmc_hold_timer.sv
// Hold timer over timebase ticks
`timescale 1ns/1ns
`default_nettype none
module lintmc_hold_timer
  import lintmc_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              resetn_i,
  // Control
  input  wire logic              tick_i,
  input  wire logic              run_i,
  input  wire logic [TIME_W-1:0] limit_i,
  // Result
  output logic                   reached_o
);
  import lintmc_pkg::*;

  logic [TIME_W-1:0] count;
  logic [TIME_W-1:0] next_count;
  wire               at_max = &count;

  // Saturating tick count
  assign next_count = !run_i ? '0 :
                      (tick_i && !at_max) ? count + 1'b1 : count;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign reached_o = run_i && (count >= limit_i);

endmodule : lintmc_hold_timer
`default_nettype wire

//--- core/lintmc_mode_ctrl.sv
// Operating-mode controller of a LIN transceiver with register access
//
// Overview of operation
// R01: Four major states: normal, stand-by, sleep, stop
// R02: Normal has slope-controlled and flash sub-modes
// R03: Enable and transmit pins select the state
// R04: Normal: transmit input, receive follows bus, regulator on
// R05: Enable low, transmit high, hold time: sleep
// R06: Enable low, transmit low, hold time: stop
// R07: Power-up lands in stand-by automatically
// R08: Stand-by plus enable high gives normal
// R09: Bus wake from sleep/stop gives stand-by
// R10: Local wake from sleep/stop gives stand-by
// R11: Undervoltage forces stand-by from any state
// R12: Stand-by: regulator on, bus stage off, terminated
// R13: Stand-by pins drive the entry cause code
// R14: Wake-up logic disabled while in stand-by
// R15: Transmit low drives dominant; receive follows bus
// R16: Normal entry lands slope-controlled; flash only from it
// R17: Stage recessive until transmit high for release time
// R18: Flash disables slope control, paths stay active
// R19: Enable low pulse with transmit edges toggles flash
// R20: Enable low otherwise leads to sleep or stop
// R21: Slope control re-enabled on every normal entry
// R22: Enable high past hold time: sleep/stop to normal
// R23: Stop to sleep with transmit high for hold
// R24: Bus wake: dominant past filter, acts on rise
// R25: Local wake: low past filter, short pulses ignored
// R26: All durations counted on a timebase, configurable; flash toggle times are fixed constants here
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module lintmc_mode_ctrl
  import lintmc_pkg::*;
(
  // Clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          resetn_i,
  // Register bus
  input  wire lintmc_pkg::lintmc_axi_req_type  axi_req_i,
  output lintmc_pkg::lintmc_axi_resp_type      axi_resp_o,
  // Host pins
  input  wire logic          enable_i,
  input  wire logic          transmit_in_i,
  output logic               transmit_out_o,
  output logic               transmit_oe_o,
  output logic               receive_out_o,
  output logic               receive_oe_o,
  // Bus and wake pins
  input  wire logic          lin_rx_i,
  output logic               lin_dominant_o,
  output logic               lin_tx_enable_o,
  output logic               bus_receiver_en_o,
  output logic               termination_en_o,
  output logic               slope_ctrl_en_o,
  input  wire logic          local_wake_n_i,
  // Supply
  input  wire logic          vs_undervoltage_i,
  output logic               regulator_en_o
);
  import lintmc_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Timebase
  logic [7:0] tick_cnt;
  wire        tick = (tick_cnt == 8'(TICK_CYCLES - 1));

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick ? 8'h00 : tick_cnt + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [15:0] mode_hold;
  logic [15:0] release_time;
  logic [15:0] bus_filt;
  logic [15:0] local_filt;

  //////////////////////////////////////////////////////////////////////////
  // State
  lintmc_state_type state;
  lintmc_state_type next_state;
  logic             flash_mode;
  logic [1:0]       cause;
  logic [1:0]       next_cause;
  logic             tx_released;
  logic             bus_armed;
  logic             txd_q;
  logic             lin_q;
  logic             en_q;
  logic             rx_data;

  wire is_normal  = (state == ST_NORMAL);
  wire is_standby = (state == ST_STANDBY);
  wire is_sleep   = (state == ST_SLEEP);
  wire is_stop    = (state == ST_STOP);
  wire is_low_pwr = is_sleep || is_stop;
  wire txd_rise   = transmit_in_i && !txd_q;
  wire txd_fall   = !transmit_in_i && txd_q;
  wire lin_rise   = lin_rx_i && !lin_q;
  wire en_rise    = enable_i && !en_q;

  //////////////////////////////////////////////////////////////////////////
  // Hold timers
  logic [TMR_NUM-1:0] tmr_run;
  logic [TMR_NUM-1:0] tmr_hit;
  logic [15:0]        tmr_limit [TMR_NUM];
  wire                state_chg = (next_state != state);

  assign tmr_run[TMR_EN]      = enable_i;
  assign tmr_run[TMR_MODE]    = !enable_i && (transmit_in_i == txd_q);
  assign tmr_run[TMR_BUS]     = is_low_pwr && !lin_rx_i;
  assign tmr_run[TMR_LOCAL]   = is_low_pwr && !local_wake_n_i;
  assign tmr_limit[TMR_EN]    = mode_hold;
  assign tmr_limit[TMR_MODE]  = mode_hold;
  assign tmr_limit[TMR_BUS]   = bus_filt;
  assign tmr_limit[TMR_LOCAL] = local_filt;
  assign tmr_limit[TMR_REL]   = release_time;

  genvar gi;
  generate
    for (gi = 0; gi < TMR_NUM; gi++) begin : g_tmr
      lintmc_hold_timer u_tmr (                         // [R26]
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .tick_i     (tick),
        .run_i      (tmr_run[gi]),
        .limit_i    (tmr_limit[gi]),
        .reached_o  (tmr_hit[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Flash toggle
  logic [15:0] en_low_cnt;
  logic [15:0] fall_at;
  logic        fall_seen;
  logic        rise_ok;
  wire         low_phase = is_normal && !enable_i;
  wire         fall_ok   = en_low_cnt >= FLASH_EDGE_US;
  wire         rise_gap  = (en_low_cnt - fall_at) >= FLASH_EDGE2_US;
  wire         flash_tog = is_normal && en_rise && rise_ok &&
                           (en_low_cnt >= FLASH_EN_LOW_US);     // [R19]
  assign tmr_run[TMR_REL] = transmit_in_i && !state_chg && !flash_tog; // [R17]

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_low_cnt <= '0;
      fall_at    <= '0;
      fall_seen  <= 1'b0;
      rise_ok    <= 1'b0;
    end else if (!low_phase) begin
      if (enable_i && !en_rise) begin
        en_low_cnt <= '0;
        fall_seen  <= 1'b0;
        rise_ok    <= 1'b0;
      end
    end else begin
      if (tick && !(&en_low_cnt)) begin
        en_low_cnt <= en_low_cnt + 16'h0001;
      end
      if (txd_fall && fall_ok && !fall_seen) begin
        fall_seen <= 1'b1;
        fall_at   <= en_low_cnt;
      end
      if (txd_rise && fall_seen && rise_gap) begin
        rise_ok <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Mode state machine
  always_comb begin
    next_state = state;
    next_cause = cause;
    if (vs_undervoltage_i) begin
      next_state = ST_STANDBY;                          // [R11]
      next_cause = CAUSE_PWR;
    end else begin
      case (state)                                      // [R01] [R03]
        ST_NORMAL: begin
          if (tmr_hit[TMR_MODE] && !rise_ok) begin      // [R20]
            next_state = txd_q ? ST_SLEEP : ST_STOP;    // [R05] [R06]
          end
        end
        ST_STANDBY: begin
          if (enable_i) begin                           // [R08]
            next_state = ST_NORMAL;
          end
        end
        ST_SLEEP, ST_STOP: begin
          if (tmr_hit[TMR_EN]) begin                    // [R22]
            next_state = ST_NORMAL;
          end else if (bus_armed && lin_rise) begin     // [R09] [R24]
            next_state = ST_STANDBY;
            next_cause = CAUSE_BUS;
          end else if (tmr_hit[TMR_LOCAL]) begin        // [R10] [R25]
            next_state = ST_STANDBY;
            next_cause = CAUSE_LOCAL;
          end else if (is_stop && txd_q &&
                       tmr_hit[TMR_MODE]) begin         // [R23]
            next_state = ST_SLEEP;
          end
        end
        default: begin
          next_state = ST_STANDBY;
          next_cause = CAUSE_PWR;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ST_STANDBY;                              // [R07]
      cause <= CAUSE_PWR;
    end else begin
      state <= next_state;
      cause <= next_cause;
    end
  end

  // Sub-mode select
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flash_mode <= 1'b0;
    end else if (next_state != ST_NORMAL || !is_normal) begin
      flash_mode <= 1'b0;                               // [R16] [R21]
    end else if (flash_tog) begin
      flash_mode <= !flash_mode;                        // [R02] [R19]
    end
  end

  // Bus wake arming
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_armed <= 1'b0;
    end else if (!is_low_pwr) begin
      bus_armed <= 1'b0;                                // [R14]
    end else if (tmr_hit[TMR_BUS]) begin
      bus_armed <= 1'b1;                                // [R24]
    end
  end

  // Output stage release
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_released <= 1'b0;
    end else if (state_chg || flash_tog) begin
      tx_released <= 1'b0;                              // [R17]
    end else if (tmr_hit[TMR_REL]) begin
      tx_released <= 1'b1;                              // [R17]
    end
  end

  // Pin history
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      txd_q   <= 1'b0;
      lin_q   <= 1'b1;
      en_q    <= 1'b0;
      rx_data <= 1'b1;
    end else begin
      txd_q   <= transmit_in_i;
      lin_q   <= lin_rx_i;
      en_q    <= enable_i;
      rx_data <= is_standby ? cause[1] : lin_rx_i;      // [R13] [R15]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign receive_out_o     = rx_data;
  assign receive_oe_o      = is_normal || is_standby;   // [R04] [R05]
  assign transmit_out_o    = cause[0];                  // [R13]
  assign transmit_oe_o     = is_standby;                // [R13]
  assign lin_tx_enable_o   = is_normal && tx_released;  // [R12] [R17]
  assign lin_dominant_o    = lin_tx_enable_o && !txd_q; // [R15]
  assign bus_receiver_en_o = is_normal;                 // [R12] [R18]
  assign termination_en_o  = is_normal || is_standby;   // [R04] [R06]
  assign slope_ctrl_en_o   = !flash_mode;               // [R18]
  assign regulator_en_o    = !is_sleep;                 // [R04] [R05]

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic        aw_full;
  logic        w_full;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        bvalid;
  logic [1:0]  bresp;
  logic        rvalid;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic [31:0] rd_mux;
  logic        rd_hit;

  wire awready   = !aw_full && !bvalid;
  wire wready    = !w_full && !bvalid;
  wire aw_take   = axi_req_i.awvalid && awready;
  wire w_take    = axi_req_i.wvalid && wready;
  wire aw_have   = aw_full || aw_take;
  wire w_have    = w_full || w_take;
  wire do_write  = aw_have && w_have && !bvalid;
  wire [31:0] wa = aw_full ? aw_addr : axi_req_i.awaddr;
  wire [31:0] wd = w_full ? w_data : axi_req_i.wdata;
  wire [3:0]  ws = w_full ? w_strb : axi_req_i.wstrb;
  wire wr_hold   = do_write && (wa == MODE_HOLD_OFFSET);
  wire wr_rel    = do_write && (wa == RELEASE_OFFSET);
  wire wr_bus    = do_write && (wa == BUS_FILT_OFFSET);
  wire wr_loc    = do_write && (wa == LOCAL_FILT_OFFSET);
  wire wr_ok     = wr_hold || wr_rel || wr_bus || wr_loc ||
                   (wa == STATUS_OFFSET);
  wire arready   = !rvalid;
  wire ar_take   = axi_req_i.arvalid && arready;

  function automatic logic [15:0] merge(input logic [15:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    merge = {strb[1] ? new_v[15:8] : old_v[15:8],
             strb[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction : merge

  wire [31:0] status_word = {23'h000000, bus_armed, tx_released, cause,
                             flash_mode, state};

  always_comb begin
    rd_hit = 1'b1;
    case (axi_req_i.araddr)
      STATUS_OFFSET:     rd_mux = status_word;
      MODE_HOLD_OFFSET:  rd_mux = {16'h0000, mode_hold};
      RELEASE_OFFSET:    rd_mux = {16'h0000, release_time};
      BUS_FILT_OFFSET:   rd_mux = {16'h0000, bus_filt};
      LOCAL_FILT_OFFSET: rd_mux = {16'h0000, local_filt};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      if (do_write) begin
        aw_full <= 1'b0;
        w_full  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_full <= 1'b1;
          aw_addr <= axi_req_i.awaddr;
        end
        if (w_take) begin
          w_full <= 1'b1;
          w_data <= axi_req_i.wdata;
          w_strb <= axi_req_i.wstrb;
        end
        if (bvalid && axi_req_i.bready) begin
          bvalid <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_hold    <= MODE_HOLD_US_RST;
      release_time <= RELEASE_US_RST;
      bus_filt     <= BUS_FILT_US_RST;
      local_filt   <= LOCAL_FILT_US_RST;
    end else begin
      if (wr_hold) mode_hold <= merge(mode_hold, wd, ws);       // [R26]
      if (wr_rel)  release_time <= merge(release_time, wd, ws); // [R26]
      if (wr_bus)  bus_filt <= merge(bus_filt, wd, ws);         // [R26]
      if (wr_loc)  local_filt <= merge(local_filt, wd, ws);     // [R26]
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && axi_req_i.rready) begin
      rvalid <= 1'b0;
    end
  end

  assign axi_resp_o.awready = awready;
  assign axi_resp_o.wready  = wready;
  assign axi_resp_o.bvalid  = bvalid;
  assign axi_resp_o.bresp   = bresp;
  assign axi_resp_o.arready = arready;
  assign axi_resp_o.rvalid  = rvalid;
  assign axi_resp_o.rdata   = rdata;
  assign axi_resp_o.rresp   = rresp;

endmodule : lintmc_mode_ctrl
`default_nettype wire

//--- testbench/lintmc_sva.sv
// Checker of the LIN mode controller
`timescale 1ns/1ns
`default_nettype none
module lintmc_sva (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Host pins
  input wire logic enable_i,
  input wire logic transmit_in_i,
  input wire logic transmit_out_o,
  input wire logic transmit_oe_o,
  input wire logic receive_out_o,
  input wire logic receive_oe_o,
  // Bus and supply
  input wire logic lin_rx_i,
  input wire logic lin_dominant_o,
  input wire logic lin_tx_enable_o,
  input wire logic bus_receiver_en_o,
  input wire logic termination_en_o,
  input wire logic slope_ctrl_en_o,
  input wire logic vs_undervoltage_i,
  input wire logic regulator_en_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////////
  sequence s_std_idle;
    transmit_oe_o && !enable_i && !vs_undervoltage_i;
  endsequence
  sequence s_std_go;
    transmit_oe_o && enable_i && !vs_undervoltage_i;
  endsequence
  property p_uv;
    vs_undervoltage_i [*2] |=> transmit_oe_o && receive_out_o
      && !transmit_out_o;
  endproperty
  property p_sleep;
    !regulator_en_o |-> !receive_oe_o && !termination_en_o && !transmit_oe_o;
  endproperty
  property p_float;
    !receive_oe_o |-> !bus_receiver_en_o && !lin_tx_enable_o
      && !termination_en_o && slope_ctrl_en_o;
  endproperty
  property p_std;
    transmit_oe_o |-> regulator_en_o && termination_en_o && receive_oe_o
      && !bus_receiver_en_o && !lin_tx_enable_o;
  endproperty
  property p_rx;
    bus_receiver_en_o && $past(bus_receiver_en_o)
      |-> receive_out_o == $past(lin_rx_i);
  endproperty
  property p_dom;
    lin_dominant_o |-> !$past(transmit_in_i);
  endproperty
  property p_rel;
    $rose(lin_tx_enable_o) |-> $past(transmit_in_i)
      && $past(transmit_in_i, 8) && bus_receiver_en_o;
  endproperty
  property p_en;
    s_std_go |=> bus_receiver_en_o;
  endproperty
  property p_hold;
    bus_receiver_en_o && enable_i && !vs_undervoltage_i
      |=> bus_receiver_en_o && !transmit_oe_o;
  endproperty
  property p_flash;
    $fell(slope_ctrl_en_o) |-> $past(enable_i) && !$past(enable_i, 2)
      && bus_receiver_en_o;
  endproperty
  property p_wake_off;
    s_std_idle |=> transmit_oe_o && $stable(transmit_out_o);
  endproperty
  ////////////////////////////////////////////////////////////////////
  a_uv: assert property (p_uv)
    else $error("uv standby");
  a_sleep: assert property (p_sleep)
    else $error("sleep pins");
  a_float: assert property (p_float)
    else $error("float pins");
  a_std: assert property (p_std)
    else $error("standby pins");
  a_rx: assert property (p_rx)
    else $error("rx follow");
  a_dom: assert property (p_dom)
    else $error("dominant");
  a_rel: assert property (p_rel)
    else $error("early release");
  a_en: assert property (p_en)
    else $error("standby exit");
  a_hold: assert property (p_hold)
    else $error("normal left");
  a_flash: assert property (p_flash)
    else $error("flash entry");
  a_wake_off: assert property (p_wake_off)
    else $error("cause changed");
endmodule : lintmc_sva
bind lintmc_mode_ctrl lintmc_sva lintmc_sva_inst (.*);
`default_nettype wire

//--- testbench/lintmc_host_model.sv
// Host model driving enable and transmit pins
`timescale 1ns/1ns
`default_nettype none
module lintmc_host_model (
  // Clock
  input  wire logic core_clk_i,
  // Host pins
  output var logic  enable_o,
  output var logic  txd_o
);
  initial begin
    enable_o = 1'b0;
    txd_o    = 1'b1;
  end
  // Set pins, hold n cycles
  task automatic pins(input logic e, input logic t, input int n);
    @(posedge core_clk_i);
    enable_o <= e;
    txd_o    <= t;
    repeat (n) @(posedge core_clk_i);
  endtask : pins
  // Flash toggle sequence
  task automatic flash();
    pins(1'b0, 1'b1, 120);
    pins(1'b0, 1'b0, 120);
    pins(1'b0, 1'b1, 200);
    pins(1'b1, 1'b1, 2);
  endtask : flash
endmodule : lintmc_host_model
`default_nettype wire

//--- testbench/tb_top.sv
// Testbench of the LIN mode controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import lintmc_pkg::*;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic vs_undervoltage_i = 1'b0;
  logic [1:0] wk = 2'h3;
  logic enable_i, host_txd, transmit_in_i, transmit_out_o, transmit_oe_o;
  logic receive_out_o, receive_oe_o, lin_dominant_o, lin_tx_enable_o;
  logic bus_receiver_en_o, termination_en_o, slope_ctrl_en_o;
  logic regulator_en_o;
  lintmc_axi_req_type  axi_req_i = '0;
  lintmc_axi_resp_type axi_resp_o;
  int err_total = 0;
  int check_count = 0;
  int m_state, m_cause, m_flash;
  logic [31:0] lfsr = 32'hc0eb3386;
  logic [31:0] d;
  logic [31:0] offs[4] = '{MODE_HOLD_OFFSET, RELEASE_OFFSET,
                           BUS_FILT_OFFSET, LOCAL_FILT_OFFSET};
  logic [15:0] dflt[4] = '{MODE_HOLD_US_RST, RELEASE_US_RST,
                           BUS_FILT_US_RST, LOCAL_FILT_US_RST};
  logic [15:0] news[4] = '{16'h001e, 16'h0002, 16'h0003, 16'h0003};
  always #25 core_clk_i = ~core_clk_i;
  assign transmit_in_i = transmit_oe_o ? transmit_out_o : host_txd;
  lintmc_mode_ctrl lintmc_mode_ctrl_inst (
    .core_clk_i, .resetn_i, .axi_req_i, .axi_resp_o, .enable_i,
    .transmit_in_i, .transmit_out_o, .transmit_oe_o, .receive_out_o,
    .receive_oe_o, .lin_rx_i(wk[0]), .lin_dominant_o, .lin_tx_enable_o,
    .bus_receiver_en_o, .termination_en_o, .slope_ctrl_en_o,
    .local_wake_n_i(wk[1]), .vs_undervoltage_i, .regulator_en_o);
  lintmc_host_model lintmc_host_model_inst (
    .core_clk_i, .enable_o(enable_i), .txd_o(host_txd));
  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string nm);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    @(posedge core_clk_i);
    axi_req_i <= '{1'b1, a, 1'b1, v, 4'hf, 1'b1, 1'b0, 32'h0, 1'b0};
    do begin
      @(posedge core_clk_i);
      if (axi_resp_o.awready) axi_req_i.awvalid <= 1'b0;
      if (axi_resp_o.wready) axi_req_i.wvalid <= 1'b0;
    end while (!axi_resp_o.bvalid);
    axi_req_i.bready <= 1'b0;
    chk(32'(axi_resp_o.bresp), 32'(er), "bresp");
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [1:0] er);
    @(posedge core_clk_i);
    axi_req_i <= '{1'b0, 32'h0, 1'b0, 32'h0, 4'h0, 1'b0, 1'b1, a, 1'b1};
    do begin
      @(posedge core_clk_i);
      if (axi_resp_o.arready) axi_req_i.arvalid <= 1'b0;
    end while (!axi_resp_o.rvalid);
    d = axi_resp_o.rdata;
    axi_req_i.rready <= 1'b0;
    chk(32'(axi_resp_o.rresp), 32'(er), "rresp");
  endtask : rd
  // Status and pins vs model
  task automatic st();
    logic [31:0] m;
    m = (m_state == 2) ? 32'h7f : 32'h1f;
    rd(STATUS_OFFSET, RESP_OKAY);
    chk(d & m, 32'((m_cause << 5) | (m_flash << 4) | m_state) & m, "st");
    if (m_state == 2) begin
      chk(32'({receive_out_o, transmit_out_o}), 32'(m_cause), "cause");
    end
  endtask : st
  task automatic hp(input logic e, input logic t, input int n);
    lintmc_host_model_inst.pins(e, t, n);
  endtask : hp
  task automatic pulse(input logic [1:0] v, input int n);
    @(posedge core_clk_i);
    wk <= v;
    repeat (n) @(posedge core_clk_i);
    wk <= 2'h3;
    repeat (20) @(posedge core_clk_i);
  endtask : pulse
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge core_clk_i);
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    m_state = 2;
    m_cause = 2;
    m_flash = 0;
    st();
    foreach (offs[i]) begin
      rd(offs[i], RESP_OKAY);
      chk(d, 32'(dflt[i]), "reset");
      wr(offs[i], 32'(news[i]), RESP_OKAY);
      rd(offs[i], RESP_OKAY);
      chk(d, 32'(news[i]), "readback");
    end
    rd(32'h0000_0040, RESP_SLVERR);
    chk(d, 32'h0, "unmapped");
    wr(STATUS_OFFSET, 32'hffff_ffff, RESP_OKAY);
    st();
    hp(1'b1, 1'b0, 4);
    m_state = 1;
    st();
    chk(32'(lin_tx_enable_o), 32'h0, "held");
    hp(1'b1, 1'b1, 80);
    chk(32'(lin_tx_enable_o), 32'h1, "released");
    repeat (16) begin
      lfsr = nxt(lfsr);
      hp(1'b1, lfsr[0], 0);
      wk[0] <= lfsr[1];
      repeat (2) @(posedge core_clk_i);
      @(negedge core_clk_i);
      chk(32'(receive_out_o), 32'(lfsr[1]), "rx");
      chk(32'(lin_dominant_o), 32'(!lfsr[0]), "dom");
    end
    wk <= 2'h3;
    for (int k = 0; k < 3; k++) begin
      lintmc_host_model_inst.flash();
      m_flash = 1 - m_flash;
      @(negedge core_clk_i);
      chk(32'(slope_ctrl_en_o), 32'(!m_flash), "slope");
      chk(32'(lin_tx_enable_o), 32'h0, "toggle hold");
      st();
    end
    hp(1'b0, 1'b0, 700);
    m_state = 8;
    m_flash = 0;
    st();
    chk(32'({regulator_en_o, slope_ctrl_en_o}), 32'h3, "stop");
    hp(1'b0, 1'b1, 700);
    m_state = 4;
    st();
    chk(32'(regulator_en_o), 32'h0, "sleep");
    pulse(2'h1, 40);
    st();
    pulse(2'h1, 100);
    m_state = 2;
    m_cause = 0;
    st();
    pulse(2'h0, 100);
    st();
    hp(1'b1, 1'b1, 4);
    hp(1'b0, 1'b1, 700);
    m_state = 4;
    st();
    wk <= 2'h2;
    repeat (100) @(posedge core_clk_i);
    st();
    wk <= 2'h3;
    repeat (20) @(posedge core_clk_i);
    m_state = 2;
    m_cause = 1;
    st();
    hp(1'b1, 1'b1, 4);
    hp(1'b0, 1'b0, 700);
    m_state = 8;
    hp(1'b1, 1'b0, 100);
    st();
    hp(1'b1, 1'b0, 600);
    m_state = 1;
    st();
    vs_undervoltage_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    m_state = 2;
    m_cause = 2;
    st();
    vs_undervoltage_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
